// *** pkg/cfm_params.svh ***
// Purpose: offsets, field positions and the filter reset value of the filter register block
// Assumes: word-indexed register port, 16-bit data
// Notes: definitions only
`ifndef CFM_PARAMS_SVH
`define CFM_PARAMS_SVH
`define CFM_ADDR_W          4
`define CFM_OFF_FILTER      4'h0
`define CFM_OFF_CTRL        4'h1
`define CFM_OFF_MSG_ID      4'h2
`define CFM_OFF_MSG_EID     4'h3
`define CFM_OFF_STATUS      4'h4
`define CFM_SID_HI          15
`define CFM_SID_LO          5
`define CFM_TYPE_BIT        3
`define CFM_EID_HI          1
`define CFM_EID_LO          0
`define CFM_FILTER_WMASK    16'hFFEB
`define CFM_FILTER_RST      16'h0000
`endif

// *** pkg/cfm_pkg.sv ***
// Purpose: types shared by the filter match block
// Assumes: nothing
// Notes: constants live in cfm_params.svh
package cfm_pkg;
  typedef logic [15:0] cfm_word_t;
  typedef logic [3:0]  cfm_addr_t;
  typedef logic [10:0] cfm_sid_t;
  typedef logic [1:0]  cfm_eid_t;
endpackage : cfm_pkg

// *** core/cfm_compare.sv ***
// Purpose: combinational compare of one message identifier against the filter
// Assumes: inputs already registered by the caller
// Notes: no state
`timescale 1ns/100ps
module cfm_compare (
  input  wire cfm_pkg::cfm_sid_t pat_sid,
  input  wire cfm_pkg::cfm_eid_t pat_eid,
  input  wire logic              type_sel,
  input  wire logic              type_en,
  input  wire cfm_pkg::cfm_sid_t msg_sid,
  input  wire cfm_pkg::cfm_eid_t msg_eid,
  input  wire logic              msg_ext,
  output logic                   hit
);
  import cfm_pkg::*;
  logic [12:0] diff;
  logic        type_ok;
  always_comb begin
    diff    = {pat_sid, pat_eid} ^ {msg_sid, msg_eid};
    type_ok = !type_en || (type_sel == msg_ext);
    hit     = (diff == 13'h0000) && type_ok;
  end
endmodule : cfm_compare

// *** core/cfm_top.sv ***
// Purpose: acceptance filter register with identifier compare
// Assumes: register port with one-cycle read latency
// Notes: extended bits compared only on extended frames would be a mask-side choice; here always compared
`timescale 1ns/100ps
`include "cfm_params.svh"

module cfm_top (
  input  wire logic               CLK,
  input  wire logic               RESET_N,
  input  wire cfm_pkg::cfm_addr_t ADDR,
  input  wire cfm_pkg::cfm_word_t WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output cfm_pkg::cfm_word_t      RDATA,
  output logic                    MATCH
);
  import cfm_pkg::*;

  cfm_word_t filt_q, filt_d;
  logic      type_en_q, type_en_d;
  cfm_word_t msg_id_q, msg_id_d;
  cfm_word_t msg_eid_q, msg_eid_d;
  cfm_word_t rdata_q, rdata_d;
  logic      match_q, match_d;
  logic      hit;

  // only implemented bits store, so 4 and 2 can never read back
  always_comb begin
    filt_d    = filt_q;
    type_en_d = type_en_q;
    msg_id_d  = msg_id_q;
    msg_eid_d = msg_eid_q;
    if (WR) begin
      unique case (ADDR)
        `CFM_OFF_FILTER:  filt_d = WDATA & `CFM_FILTER_WMASK;
        `CFM_OFF_CTRL:    type_en_d = WDATA[0];
        `CFM_OFF_MSG_ID:  msg_id_d = WDATA;
        `CFM_OFF_MSG_EID: msg_eid_d = WDATA;
        default:          ;
      endcase
    end
  end

  always_comb begin
    rdata_d = 16'h0000;
    if (RD) begin
      unique case (ADDR)
        `CFM_OFF_FILTER:  rdata_d = filt_q & `CFM_FILTER_WMASK;
        `CFM_OFF_CTRL:    rdata_d = {15'h0000, type_en_q};
        `CFM_OFF_MSG_ID:  rdata_d = msg_id_q;
        `CFM_OFF_MSG_EID: rdata_d = msg_eid_q;
        `CFM_OFF_STATUS:  rdata_d = {15'h0000, match_q};
        default:          rdata_d = 16'h0000;
      endcase
    end
  end

  cfm_compare u_cmp (
    .pat_sid  (filt_q[`CFM_SID_HI:`CFM_SID_LO]),
    .pat_eid  (filt_q[`CFM_EID_HI:`CFM_EID_LO]),
    .type_sel (filt_q[`CFM_TYPE_BIT]),
    .type_en  (type_en_q),
    .msg_sid  (msg_id_q[10:0]),
    .msg_eid  (msg_eid_q[1:0]),
    .msg_ext  (msg_id_q[15]),
    .hit      (hit)
  );

  always_comb begin
    match_d = hit;
  end

  // reset value stands in for the unknown power-on state
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      filt_q    <= `CFM_FILTER_RST;
      type_en_q <= 1'b0;
      msg_id_q  <= 16'h0000;
      msg_eid_q <= 16'h0000;
      rdata_q   <= 16'h0000;
      match_q   <= 1'b0;
    end else begin
      filt_q    <= filt_d;
      type_en_q <= type_en_d;
      msg_id_q  <= msg_id_d;
      msg_eid_q <= msg_eid_d;
      rdata_q   <= rdata_d;
      match_q   <= match_d;
    end
  end

  assign RDATA = rdata_q;
  assign MATCH = match_q;

  property p_unimpl_zero;
    @(posedge CLK) disable iff (!RESET_N)
      RD && ADDR == `CFM_OFF_FILTER |=> (RDATA[4] == 1'b0) && (RDATA[2] == 1'b0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read nonzero");

  property p_sid_one;
    @(posedge CLK) disable iff (!RESET_N)
      (filt_q[`CFM_SID_HI:`CFM_SID_LO] & ~msg_id_q[10:0]) != 11'h000 |=> !MATCH;
  endproperty
  a_sid_one: assert property (p_sid_one) else $error("match with pattern one on message zero");

  property p_sid_zero;
    @(posedge CLK) disable iff (!RESET_N)
      (~filt_q[`CFM_SID_HI:`CFM_SID_LO] & msg_id_q[10:0]) != 11'h000 |=> !MATCH;
  endproperty
  a_sid_zero: assert property (p_sid_zero) else $error("match with pattern zero on message one");

  property p_ext_only;
    @(posedge CLK) disable iff (!RESET_N)
      type_en_q && filt_q[`CFM_TYPE_BIT] && !msg_id_q[15] |=> !MATCH;
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("standard frame matched extended filter");

  property p_std_only;
    @(posedge CLK) disable iff (!RESET_N)
      type_en_q && !filt_q[`CFM_TYPE_BIT] && msg_id_q[15] |=> !MATCH;
  endproperty
  a_std_only: assert property (p_std_only) else $error("extended frame matched standard filter");

  // sampled reset in the antecedent: the edge that leaves reset still shows the cleared match
  property p_type_ignored;
    @(posedge CLK) disable iff (!RESET_N)
      RESET_N && !type_en_q && (filt_q[`CFM_SID_HI:`CFM_SID_LO] == msg_id_q[10:0])
        && (filt_q[`CFM_EID_HI:`CFM_EID_LO] == msg_eid_q[1:0]) |=> MATCH;
  endproperty
  a_type_ignored: assert property (p_type_ignored) else $error("type bit not ignored");

  property p_eid_one;
    @(posedge CLK) disable iff (!RESET_N)
      (filt_q[`CFM_EID_HI:`CFM_EID_LO] != msg_eid_q[1:0]) |=> !MATCH;
  endproperty
  a_eid_one: assert property (p_eid_one) else $error("ext bit mismatch matched");

  sequence s_filter_write;
    WR && ADDR == `CFM_OFF_FILTER;
  endsequence

  sequence s_filter_read;
    RD && !WR && ADDR == `CFM_OFF_FILTER;
  endsequence

  property p_write_back;
    @(posedge CLK) disable iff (!RESET_N)
      s_filter_write ##1 s_filter_read |=> RDATA == ($past(WDATA, 2) & `CFM_FILTER_WMASK);
  endproperty
  a_write_back: assert property (p_write_back) else $error("filter readback wrong");

  property p_filter_store;
    @(posedge CLK) disable iff (!RESET_N)
      s_filter_write |=> filt_q == ($past(WDATA) & `CFM_FILTER_WMASK);
  endproperty
  a_filter_store: assert property (p_filter_store) else $error("filter write not stored");

  property p_unimpl_hold;
    @(posedge CLK) disable iff (!RESET_N)
      (filt_q[4] == 1'b0) && (filt_q[2] == 1'b0);
  endproperty
  a_unimpl_hold: assert property (p_unimpl_hold) else $error("unimplemented filter bit stored");

  property p_ctrl_store;
    @(posedge CLK) disable iff (!RESET_N)
      WR && ADDR == `CFM_OFF_CTRL |=> type_en_q == $past(WDATA[0]);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("type enable write not stored");

  property p_msg_store;
    @(posedge CLK) disable iff (!RESET_N)
      WR && ADDR == `CFM_OFF_MSG_ID |=> msg_id_q == $past(WDATA);
  endproperty
  a_msg_store: assert property (p_msg_store) else $error("message id write not stored");

  property p_eid_bit_one;
    @(posedge CLK) disable iff (!RESET_N)
      (filt_q[`CFM_EID_HI:`CFM_EID_LO] & ~msg_eid_q[1:0]) != 2'h0 |=> !MATCH;
  endproperty
  a_eid_bit_one: assert property (p_eid_bit_one) else $error("ext pattern one matched message zero");

  property p_match_full;
    @(posedge CLK) disable iff (!RESET_N)
      RESET_N && (filt_q[`CFM_SID_HI:`CFM_SID_LO] == msg_id_q[10:0])
        && (filt_q[`CFM_EID_HI:`CFM_EID_LO] == msg_eid_q[1:0])
        && (!type_en_q || (filt_q[`CFM_TYPE_BIT] == msg_id_q[15])) |=> MATCH;
  endproperty
  a_match_full: assert property (p_match_full) else $error("all bits agree but no match");

  property p_status_back;
    @(posedge CLK) disable iff (!RESET_N)
      RD && ADDR == `CFM_OFF_STATUS |=> RDATA == {15'h0000, $past(MATCH)};
  endproperty
  a_status_back: assert property (p_status_back) else $error("status read differs from match");

  property p_unmapped_zero;
    @(posedge CLK) disable iff (!RESET_N)
      RD && ADDR > `CFM_OFF_STATUS |=> RDATA == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

  property p_rdata_idle;
    @(posedge CLK) disable iff (!RESET_N)
      !RD |=> RDATA == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read strobe");

  // no disable here: this one watches reset itself
  property p_reset_quiet;
    @(posedge CLK)
      !RESET_N |=> !MATCH && (RDATA == 16'h0000);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");

  // one check per standard-id pattern bit, so a failure names the bit
  for (genvar b = 0; b < 11; b++) begin : g_sid_bit
    property p_sid_bit;
      @(posedge CLK) disable iff (!RESET_N)
        filt_q[`CFM_SID_LO + b] != msg_id_q[b] |=> !MATCH;
    endproperty
    a_sid_bit: assert property (p_sid_bit) else $error("pattern bit differs yet matched");
  end
endmodule : cfm_top

// *** tb/cfm_node.sv ***
// Purpose: remote node that lays out a received frame as message words
// Assumes: bit15 of id word flags an extended frame
// Notes: no timing, frame already captured
`timescale 1ns/100ps
module cfm_node (
  input  wire cfm_pkg::cfm_sid_t std_id_pattern,
  input  wire cfm_pkg::cfm_eid_t ext_id_high_pattern,
  input  wire logic              ext,
  output cfm_pkg::cfm_word_t     id_word,
  output cfm_pkg::cfm_word_t     eid_word
);
  assign id_word  = {ext, 4'h0, std_id_pattern};
  assign eid_word = {14'h0000, ext_id_high_pattern};
endmodule : cfm_node

// *** tb/tb_can_filter_std_id_match.sv ***
// Purpose: self-checking bench for cfm_top
// Assumes: one clock, synchronous reset
// Notes: read results checked through a queue
`timescale 1ns/100ps
`include "cfm_params.svh"
module tb_can_filter_std_id_match;
  import cfm_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, ext = 1'b0, match, m;
  logic        st_q = 1'b0, mq[$];
  cfm_addr_t   addr = 4'h0;
  cfm_word_t   wdata = 16'h0000, rdata, idw, eidw, flt, q[$];
  cfm_sid_t    std_id_pattern = 11'h000;
  cfm_eid_t    ext_id_high_pattern = 2'h0;
  logic [31:0] seed = 32'd19, r, r2;
  int          num_errors = 0, check_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  cfm_top DUT (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
               .RDATA(rdata), .MATCH(match));
  cfm_node node (.std_id_pattern(std_id_pattern), .ext_id_high_pattern(ext_id_high_pattern), .ext(ext), .id_word(idw), .eid_word(eidw));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // strobes stay set between calls so back-to-back access never assigns twice
  task automatic acc(input logic w, input cfm_addr_t a, input cfm_word_t d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) q.push_back(d);
    if (!w && a == `CFM_OFF_STATUS) mq.push_back(d[0]);
    @(posedge clk);
  endtask : acc
  task automatic idle();
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : idle
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    rd_q <= rd;
    st_q <= rd && addr == `CFM_OFF_STATUS;
    cyc <= cyc + 1;
    if (cyc > 4000) begin
      num_errors++;
      conclude();
    end
    if (rd_q) begin
      check_count++;
      if (rdata !== q[0]) begin
        $display("unexpected RDATA expected %h seen %h", q[0], rdata);
        num_errors++;
      end
      void'(q.pop_front());
    end
    if (st_q) begin
      check_count++;
      if (match !== mq[0]) begin
        $display("unexpected MATCH expected %b seen %b", mq[0], match);
        num_errors++;
      end
      void'(mq.pop_front());
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    acc(1'b1, `CFM_OFF_FILTER, 16'hFFFF);
    acc(1'b0, `CFM_OFF_FILTER, 16'hFFEB);
    acc(1'b1, 4'hF, 16'hFFFF);
    acc(1'b0, 4'hF, 16'h0000);
    acc(1'b0, `CFM_OFF_FILTER, 16'hFFEB);
    idle();
    $display("test register access done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    acc(1'b0, `CFM_OFF_FILTER, `CFM_FILTER_RST);
    idle();
    acc(1'b0, `CFM_OFF_STATUS, 16'h0001);
    idle();
    $display("test mid-run reset done");
    for (int i = 0; i < 60; i++) begin
      r = xs();
      r2 = xs();
      flt = r[15:0];
      ext = r2[0];
      ext_id_high_pattern = r2[1] ? flt[1:0] : r2[3:2];
      std_id_pattern = r2[4] ? flt[15:5] : r2[15:5];
      // any pattern bit differing, or a type mismatch while enabled, blocks the hit
      m = (std_id_pattern == flt[15:5]) && (ext_id_high_pattern == flt[1:0]) && (!r[16] || ext == flt[3]);
      acc(1'b1, `CFM_OFF_FILTER, flt);
      acc(1'b0, `CFM_OFF_FILTER, flt & 16'hFFEB);
      acc(1'b1, `CFM_OFF_CTRL, {15'h0000, r[16]});
      acc(1'b1, `CFM_OFF_MSG_ID, idw);
      acc(1'b1, `CFM_OFF_MSG_EID, eidw);
      idle();
      acc(1'b0, `CFM_OFF_STATUS, {15'h0000, m});
      idle();
    end
    $display("test random match done");
    conclude();
  end
endmodule : tb_can_filter_std_id_match
